// ---- src/uaf_pkg.sv ----
package uaf_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] POWER_CONTROL_REG_ADDR = 8'h87;
  localparam logic [7:0] SERIAL_CONTROL_REG_ADDR = 8'h98;
  localparam logic [7:0] SERIAL_BUFFER_ADDR = 8'h99;
  localparam logic [7:0] RATE_SELECT_ADDR = 8'h9B;
  localparam logic [7:0] OWN_ADDRESS_ADDR = 8'hA9;
  localparam logic [7:0] ADDRESS_MASK_ADDR = 8'hB9;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int SC_RX_DONE = 0;
  localparam int SC_TX_DONE = 1;
  localparam int SC_RX_NINTH = 2;
  localparam int SC_TX_NINTH = 3;
  localparam int SC_RX_ENABLE = 4;
  localparam int SC_MULTIPROC = 5;
  localparam int SC_MODE_ONE = 6;
  localparam int SC_MODE_ZERO_FE = 7;
  localparam int PC_FRAMING_CHECK = 6;
  localparam int RS_TX_TIMER2 = 0;
  localparam int RS_RX_TIMER2 = 1;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Serial modes and timing constants
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_TEN_BIT = 2'h1;
  localparam logic [3:0] DIV_LAST = 4'hF;
  localparam logic [3:0] DIV_CLEAR = 4'h0;
  localparam logic [3:0] SAMPLE_FIRST = 4'h7;
  localparam logic [3:0] SAMPLE_MID = 4'h8;
  localparam logic [3:0] SAMPLE_LAST = 4'h9;
  localparam logic [8:0] RX_PRELOAD = 9'h1FF;
  localparam logic [8:0] TX_MARKER_LEFT = 9'h001;
  localparam logic [3:0] RX_BITS_LAST = 4'h8;
  localparam logic [3:0] COUNT_ZERO = 4'h0;
  localparam logic [3:0] COUNT_ONE = 4'h1;

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_WAIT = 5'h02,
    TX_START = 5'h04,
    TX_DATA = 5'h08,
    TX_STOP = 5'h10
  } uaf_tx_state_e;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } uaf_rx_state_e;

endpackage

// ---- src/uaf_uart.sv ----
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps

module uaf_uart
  import uaf_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic T1_OVF,
  input wire logic T2_OVF,
  input wire logic RXD,
  output logic TXD
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic mode_bit_zero, mode_bit_one, multiproc_enable, rx_enable, tx_ninth;
  logic rx_ninth_bit, tx_done_flag, rx_done_flag, framing_error_flag, wr_buf;
  logic framing_check_enable, tx_src_t2, rx_src_t2, mp_active, wr_ctrl;
  logic [7:0] own_address, address_mask, rx_buffer;
  logic [1:0] mode;

  assign mode = {mode_bit_zero, mode_bit_one};
  assign wr_ctrl = WR && (ADDR == SERIAL_CONTROL_REG_ADDR);
  assign wr_buf = WR && (ADDR == SERIAL_BUFFER_ADDR);
  assign mp_active = multiproc_enable && (mode != MODE_SHIFT);

  // ----------------------------------------------------------------
  // Datapath events shared by registers and engines
  // ----------------------------------------------------------------
  logic tx_tick, rx_tick, tx_set_done, rx_fin, rx_stop_ok;
  logic rx_fe_check, addr_match, rx_accept;
  logic [8:0] rx_shift;
  logic [7:0] bcast;

  assign tx_tick = tx_src_t2 ? T2_OVF : T1_OVF;
  assign rx_tick = rx_src_t2 ? T2_OVF : T1_OVF;
  assign bcast = own_address | address_mask;
  assign addr_match = (((rx_shift[7:0] ^ own_address) & address_mask) == 8'h00)
    || (((rx_shift[7:0] ^ bcast) & bcast) == 8'h00);
  assign rx_accept = rx_fin && !rx_done_flag
    && (!mp_active || (rx_shift[8] && rx_stop_ok && addr_match));

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_bit_zero <= 1'b0;
      mode_bit_one <= 1'b0;
      multiproc_enable <= 1'b0;
      rx_enable <= 1'b0;
      tx_ninth <= 1'b0;
    end else if (wr_ctrl) begin
      if (!framing_check_enable) begin
        mode_bit_zero <= WDATA[SC_MODE_ZERO_FE];
      end
      mode_bit_one <= WDATA[SC_MODE_ONE];
      multiproc_enable <= WDATA[SC_MULTIPROC];
      rx_enable <= WDATA[SC_RX_ENABLE];
      tx_ninth <= WDATA[SC_TX_NINTH];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      framing_check_enable <= 1'b0;
      tx_src_t2 <= 1'b0;
      rx_src_t2 <= 1'b0;
      own_address <= REG_RESET;
      address_mask <= REG_RESET;
    end else if (WR) begin
      if (ADDR == POWER_CONTROL_REG_ADDR) begin
        framing_check_enable <= WDATA[PC_FRAMING_CHECK];
      end
      if (ADDR == RATE_SELECT_ADDR) begin
        tx_src_t2 <= WDATA[RS_TX_TIMER2];
        rx_src_t2 <= WDATA[RS_RX_TIMER2];
      end
      if (ADDR == OWN_ADDRESS_ADDR) begin
        own_address <= WDATA;
      end
      if (ADDR == ADDRESS_MASK_ADDR) begin
        address_mask <= WDATA;
      end
    end
  end

  // Hardware sets win over a software write in the same cycle.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_done_flag <= 1'b0;
    end else if (tx_set_done) begin
      tx_done_flag <= 1'b1;
    end else if (wr_ctrl) begin
      tx_done_flag <= WDATA[SC_TX_DONE];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_done_flag <= 1'b0;
    end else if (rx_accept) begin
      rx_done_flag <= 1'b1;
    end else if (wr_ctrl) begin
      rx_done_flag <= WDATA[SC_RX_DONE];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_ninth_bit <= 1'b0;
      rx_buffer <= REG_RESET;
    end else if (rx_accept) begin
      rx_ninth_bit <= rx_shift[8];
      rx_buffer <= rx_shift[7:0];
    end else if (wr_ctrl) begin
      rx_ninth_bit <= WDATA[SC_RX_NINTH];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      framing_error_flag <= 1'b0;
    end else if (rx_fe_check && !rx_stop_ok) begin
      framing_error_flag <= 1'b1;
    end else if (wr_ctrl && framing_check_enable) begin
      framing_error_flag <= WDATA[SC_MODE_ZERO_FE];
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = READ_ZERO;
    case (ADDR)
      SERIAL_CONTROL_REG_ADDR: begin
        next_rdata = {framing_check_enable ? framing_error_flag
                                           : mode_bit_zero,
          mode_bit_one, multiproc_enable, rx_enable, tx_ninth,
          rx_ninth_bit, tx_done_flag, rx_done_flag};
      end
      SERIAL_BUFFER_ADDR: next_rdata = rx_buffer;
      POWER_CONTROL_REG_ADDR: begin
        next_rdata[PC_FRAMING_CHECK] = framing_check_enable;
      end
      RATE_SELECT_ADDR: begin
        next_rdata[RS_TX_TIMER2] = tx_src_t2;
        next_rdata[RS_RX_TIMER2] = rx_src_t2;
      end
      OWN_ADDRESS_ADDR: next_rdata = own_address;
      ADDRESS_MASK_ADDR: next_rdata = address_mask;
      default: next_rdata = READ_ZERO;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= READ_ZERO;
    end else if (RD) begin
      RDATA <= next_rdata;
    end else begin
      RDATA <= READ_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  uaf_tx_state_e tx_state;
  logic [3:0] tx_div;
  logic [9:0] tx_shift;
  logic tx_roll;

  assign tx_roll = tx_tick && (tx_div == DIV_LAST);
  assign tx_set_done = tx_roll && (tx_state == TX_DATA)
    && (tx_shift[9:1] == TX_MARKER_LEFT);

  // Bit times follow this free divider, not the buffer write.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_div <= DIV_CLEAR;
    end else if (tx_tick) begin
      tx_div <= tx_div + COUNT_ONE;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_state <= TX_IDLE;
      tx_shift <= 10'h3FF;
    end else if (wr_buf) begin
      // Ten-bit mode puts the marker at the ninth position.
      tx_shift <= (mode == MODE_TEN_BIT) ? {2'b01, WDATA}
                                         : {1'b1, tx_ninth, WDATA};
      tx_state <= TX_WAIT;
    end else if (tx_roll) begin
      case (tx_state)
        TX_WAIT: begin
          if (mode != MODE_SHIFT) begin
            tx_state <= TX_START;
          end
        end
        TX_START: tx_state <= TX_DATA;
        TX_DATA: begin
          tx_shift <= {1'b0, tx_shift[9:1]};
          if (tx_shift[9:1] == TX_MARKER_LEFT) begin
            tx_state <= TX_STOP;
          end
        end
        TX_STOP: tx_state <= TX_IDLE;
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  logic next_txd;

  always_comb begin
    case (tx_state)
      TX_START: next_txd = 1'b0;
      TX_DATA: next_txd = tx_shift[0];
      default: next_txd = 1'b1;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      TXD <= 1'b1;
    end else begin
      TXD <= next_txd;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  uaf_rx_state_e rx_state;
  logic [3:0] rx_div, rx_cnt;
  logic [1:0] rx_votes;
  logic rx_prev, rx_fall, rx_bit, rx_decide;

  // A falling edge seen between two 16x samples starts a frame.
  assign rx_fall = rx_tick && rx_prev && !RXD && rx_enable
    && (rx_state == RX_IDLE) && (mode != MODE_SHIFT);
  assign rx_decide = rx_tick && (rx_div == SAMPLE_LAST)
    && (rx_state != RX_IDLE);
  // Majority of three samples around mid-bit rejects short glitches.
  assign rx_bit = (rx_votes[0] & rx_votes[1]) | (RXD & (rx_votes[0]
    | rx_votes[1]));

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_prev <= 1'b1;
    end else if (rx_tick) begin
      rx_prev <= RXD;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_div <= DIV_CLEAR;
    end else if (rx_fall) begin
      rx_div <= DIV_CLEAR;
    end else if (rx_tick) begin
      rx_div <= rx_div + COUNT_ONE;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_votes <= 2'b11;
    end else if (rx_tick && (rx_div == SAMPLE_FIRST)) begin
      rx_votes[0] <= RXD;
    end else if (rx_tick && (rx_div == SAMPLE_MID)) begin
      rx_votes[1] <= RXD;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_state <= RX_IDLE;
      rx_shift <= RX_PRELOAD;
      rx_cnt <= COUNT_ZERO;
      rx_fin <= 1'b0;
      rx_fe_check <= 1'b0;
      rx_stop_ok <= 1'b1;
    end else begin
      rx_fin <= 1'b0;
      rx_fe_check <= 1'b0;
      if (rx_fall) begin
        rx_state <= RX_START;
        rx_shift <= RX_PRELOAD;
      end else if (rx_decide) begin
        case (rx_state)
          RX_START: begin
            rx_cnt <= COUNT_ZERO;
            rx_state <= rx_bit ? RX_IDLE : RX_DATA;
          end
          RX_DATA: begin
            rx_shift <= {rx_bit, rx_shift[8:1]};
            rx_cnt <= rx_cnt + COUNT_ONE;
            if (rx_cnt == RX_BITS_LAST) begin
              if (mode == MODE_TEN_BIT) begin
                // Ninth sample of a ten-bit frame is the stop bit.
                rx_state <= RX_IDLE;
                rx_fin <= 1'b1;
                rx_stop_ok <= rx_bit;
                rx_fe_check <= framing_check_enable;
              end else if (framing_check_enable) begin
                rx_state <= RX_STOP;
              end else begin
                rx_state <= RX_IDLE;
                rx_fin <= 1'b1;
                rx_stop_ok <= 1'b1;
              end
            end
          end
          RX_STOP: begin
            rx_state <= RX_IDLE;
            rx_fin <= 1'b1;
            rx_stop_ok <= rx_bit;
            rx_fe_check <= 1'b1;
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_fe_sticky: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    framing_error_flag && !wr_ctrl |=> framing_error_flag)
    else $error("framing error flag dropped without a write");
  chk_fe_enabled: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $rose(framing_error_flag) |-> $past(framing_check_enable))
    else $error("framing error set while checking disabled");
  chk_tx_start_low: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    tx_roll && tx_state == TX_WAIT && mode != MODE_SHIFT && !wr_buf
    |=> ##1 !TXD)
    else $error("start bit not driven after rollover");
  chk_tx_idle_high: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    tx_state == TX_IDLE |=> TXD)
    else $error("transmit line low while idle");
  chk_tx_done_set: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    tx_set_done |=> tx_done_flag && tx_state == TX_STOP)
    else $error("transmit done not raised at frame end");
  chk_rx_preload: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    rx_fall |=> rx_shift == RX_PRELOAD && rx_div == DIV_CLEAR)
    else $error("receiver not aligned on falling edge");
  chk_rx_filter: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $rose(rx_done_flag) && $past(mp_active)
    |-> rx_ninth_bit && $past(addr_match) && $past(rx_stop_ok))
    else $error("receive done raised for filtered frame");
  chk_rx_buffer: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $rose(rx_done_flag) |-> rx_buffer == $past(rx_shift[7:0]))
    else $error("receive buffer not loaded with frame");
  chk_fe_on_stop: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    rx_fe_check && !rx_stop_ok |=> framing_error_flag)
    else $error("missing stop bit not flagged");

endmodule

// ---- tb/uaf_node.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Far serial node: sends frames to the port and collects its frames
// ----------------------------------------------------------------
module uaf_node (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tick_tx,
  input wire logic tick_rx,
  input wire logic line_in,
  output logic line_out
);
  logic [8:0] got_q[$];
  logic [8:0] sh;
  logic busy;
  int cnt;

  initial line_out = 1'b1;

  // Each bit is held for sixteen ticks; the line idles high afterwards.
  task automatic put(input logic [10:0] f, input int n);
    int i;
    int k;
    for (i = 0; i <= n; i++) begin
      line_out <= (i < n) ? f[i] : 1'b1;
      k = 0;
      while (k < 16) begin
        @(posedge clk);
        if (tick_tx) k++;
      end
    end
  endtask

  task automatic send(input logic [7:0] d, input logic stop);
    put({1'b0, stop, d, 1'b0}, 10);
  endtask

  // Long frames carry a ninth data bit, set for addresses, before stop.
  task automatic send9(input logic [8:0] d, input logic stop);
    put({stop, d, 1'b0}, 11);
  endtask

  // Samples near mid-bit; a frame is start, eight data LSB first, stop.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      cnt <= 0;
      sh <= 9'h000;
    end else if (tick_rx) begin
      if (!busy) begin
        busy <= !line_in;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
        if (cnt % 16 == 8 && cnt > 8) sh <= {line_in, sh[8:1]};
        if (cnt == 152) begin
          got_q.push_back({line_in, sh[8:1]});
          busy <= 1'b0;
        end
      end
    end
  end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps

module tb_top
  import uaf_pkg::*;
;
  logic SYS_CLK;
  logic RSTN;
  logic [7:0] ADDR;
  logic [7:0] WDATA;
  logic WR;
  logic RD;
  logic [7:0] RDATA;
  logic T1_OVF;
  logic T2_OVF;
  logic RXD;
  logic TXD;
  logic [1:0] t2sel;
  logic long_frames;
  logic [7:0] ctl;
  logic [1:0] t1c;
  logic [1:0] t2c;
  wire logic node_rx_tick;
  wire logic node_tx_tick;
  int fails;
  int n_compared;
  int unsigned seed;

  // The node hears the port's transmitter and feeds its receiver.
  assign node_rx_tick = t2sel[RS_TX_TIMER2] ? T2_OVF : T1_OVF;
  assign node_tx_tick = t2sel[RS_RX_TIMER2] ? T2_OVF : T1_OVF;

  uaf_uart i_dut (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .T1_OVF(T1_OVF),
    .T2_OVF(T2_OVF), .RXD(RXD), .TXD(TXD));

  uaf_node i_node (.clk(SYS_CLK), .rstn(RSTN), .tick_tx(node_tx_tick),
    .tick_rx(node_rx_tick), .line_in(TXD), .line_out(RXD));

  initial begin
    SYS_CLK = 1'b0;
    forever #25 SYS_CLK = ~SYS_CLK;
  end

  // ----------------------------------------------------------------
  // Rate ticks: the two timers differ so a wrong source garbles bits
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    t1c <= (t1c == 2'h3) ? 2'h0 : t1c + 2'h1;
    t2c <= (t2c == 2'h2) ? 2'h0 : t2c + 2'h1;
    T1_OVF <= (t1c == 2'h3);
    T2_OVF <= (t2c == 2'h2);
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic bit hit(int a, int own, int msk);
    int b;
    b = own | msk;
    return (((a ^ own) & msk) == 0) || ((a & b) == b);
  endfunction

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask

  task automatic tx_byte(input logic [7:0] d);
    logic [7:0] v;
    logic [8:0] got;
    int n;
    wr(SERIAL_BUFFER_ADDR, d);
    v = 8'h00;
    n = 0;
    while (v[SC_TX_DONE] !== 1'b1 && n < 400) begin
      rd(SERIAL_CONTROL_REG_ADDR, v);
      n++;
    end
    chk(v[SC_TX_DONE], 1'b1);
    wr(SERIAL_CONTROL_REG_ADDR, ctl);
    n = 0;
    while (i_node.got_q.size() == 0 && n < 400) begin
      @(posedge SYS_CLK);
      n++;
    end
    got = (i_node.got_q.size() > 0) ? i_node.got_q.pop_front() : 'x;
    chk(got, {1'b1, d});
  endtask

  // Flags are left standing so the caller decides how to clear them.
  task automatic rx_byte(input logic [8:0] d, input logic stop,
                         input logic acc, output logic [7:0] v);
    logic [7:0] b;
    if (long_frames) begin
      i_node.send9(d, stop);
    end else begin
      i_node.send(d[7:0], stop);
    end
    repeat (4) @(posedge SYS_CLK);
    rd(SERIAL_CONTROL_REG_ADDR, v);
    chk(v[SC_RX_DONE], acc);
    if (acc) begin
      chk(v[SC_RX_NINTH], long_frames ? d[8] : stop);
      rd(SERIAL_BUFFER_ADDR, b);
      chk(b, d[7:0]);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #4000000;
    fails++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] v;
    logic [7:0] a;
    int addrs[6];
    int i;
    addrs = '{'h55, 'h57, 'h5A, 'hFE, 'hFF, 'h00};
    seed = 86;
    fails = 0;
    n_compared = 0;
    RSTN = 1'b0;
    ADDR = 8'h00;
    WDATA = 8'h00;
    WR = 1'b0;
    RD = 1'b0;
    T1_OVF = 1'b0;
    T2_OVF = 1'b0;
    t1c = 2'h0;
    t2c = 2'h0;
    t2sel = 2'b00;
    long_frames = 1'b0;
    ctl = 8'h50;
    repeat (6) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    rd(OWN_ADDRESS_ADDR, v);
    chk(v, 8'h00);
    rd(ADDRESS_MASK_ADDR, v);
    chk(v, 8'h00);
    rd(8'h55, v);
    chk(v, 8'h00);
    wr(OWN_ADDRESS_ADDR, 8'hA5);
    rd(OWN_ADDRESS_ADDR, v);
    chk(v, 8'hA5);
    wr(OWN_ADDRESS_ADDR, 8'h00);
    $display("test registers done");
    wr(SERIAL_CONTROL_REG_ADDR, ctl);
    for (i = 0; i < 3; i++) tx_byte(rnd());
    $display("test transmit done");
    for (i = 0; i < 2; i++) begin
      rx_byte(rnd(), 1'b1, 1'b1, v);
      wr(SERIAL_CONTROL_REG_ADDR, ctl);
    end
    $display("test receive done");
    wr(POWER_CONTROL_REG_ADDR, 8'h40);
    rx_byte(rnd(), 1'b0, 1'b1, v);
    chk(v[SC_MODE_ZERO_FE], 1'b1);
    // With the check off, bit 7 is the mode bit, so the write spares the error flag.
    wr(POWER_CONTROL_REG_ADDR, 8'h00);
    rd(SERIAL_CONTROL_REG_ADDR, v);
    chk(v[SC_MODE_ZERO_FE], 1'b0);
    wr(SERIAL_CONTROL_REG_ADDR, ctl);
    wr(POWER_CONTROL_REG_ADDR, 8'h40);
    rx_byte(rnd(), 1'b1, 1'b1, v);
    chk(v[SC_MODE_ZERO_FE], 1'b1);
    wr(SERIAL_CONTROL_REG_ADDR, ctl);
    rd(SERIAL_CONTROL_REG_ADDR, v);
    chk(v[SC_MODE_ZERO_FE], 1'b0);
    wr(POWER_CONTROL_REG_ADDR, 8'h00);
    $display("test framing done");
    // Each direction has its own timer select, so a wrong source garbles one.
    for (i = 1; i < 4; i++) begin
      wr(RATE_SELECT_ADDR, i[7:0]);
      t2sel <= i[1:0];
      tx_byte(rnd());
      rx_byte(rnd(), 1'b1, 1'b1, v);
      wr(SERIAL_CONTROL_REG_ADDR, ctl);
    end
    wr(RATE_SELECT_ADDR, 8'h00);
    t2sel <= 2'b00;
    $display("test rate source done");
    ctl = 8'h70;
    wr(SERIAL_CONTROL_REG_ADDR, ctl);
    wr(OWN_ADDRESS_ADDR, 8'h56);
    wr(ADDRESS_MASK_ADDR, 8'hFC);
    for (i = 0; i < 9; i++) begin
      a = (i < 6) ? addrs[i][7:0] : rnd();
      rx_byte(a, 1'b1, hit(a, 'h56, 'hFC), v);
      wr(SERIAL_CONTROL_REG_ADDR, ctl);
    end
    rx_byte(8'h54, 1'b0, 1'b0, v);
    wr(SERIAL_CONTROL_REG_ADDR, ctl);
    $display("test address filter done");
    long_frames = 1'b1;
    ctl = 8'h90;
    wr(SERIAL_CONTROL_REG_ADDR, ctl);
    for (i = 0; i < 2; i++) begin
      rx_byte({i[0], rnd()}, 1'b1, 1'b1, v);
      wr(SERIAL_CONTROL_REG_ADDR, ctl);
    end
    ctl = 8'hB0;
    wr(SERIAL_CONTROL_REG_ADDR, ctl);
    for (i = 0; i < 3; i++) begin
      a = (i == 2) ? 8'h5A : 8'h55;
      rx_byte({i > 0, a}, 1'b1, i == 1, v);
      wr(SERIAL_CONTROL_REG_ADDR, ctl);
    end
    ctl = 8'h90;
    wr(SERIAL_CONTROL_REG_ADDR, ctl);
    wr(POWER_CONTROL_REG_ADDR, 8'h40);
    rx_byte({1'b1, rnd()}, 1'b0, 1'b1, v);
    chk(v[SC_MODE_ZERO_FE], 1'b1);
    // With the check on, bit 7 clears the error and spares the mode bit.
    wr(SERIAL_CONTROL_REG_ADDR, 8'h10);
    wr(POWER_CONTROL_REG_ADDR, 8'h00);
    rd(SERIAL_CONTROL_REG_ADDR, v);
    chk(v[SC_MODE_ZERO_FE], 1'b1);
    $display("test long frames done");
    summarize();
  end
endmodule
